// [src/gsps_pkg.sv]
// Purpose: shared constants and carrier types of the gated serial shifter
// Assumes: one system clock, all pin inputs already synchronous to it
// Notes: widths here shape the state struct, so they live in the package
package gsps_pkg;

    // =========================================================
    // sizes
    localparam int GSPS_STAGES = 8;
    localparam int GSPS_BUF_DEPTH = 2;
    localparam int GSPS_PTR_W = 1;
    localparam int GSPS_CNT_W = 2;

    // =========================================================
    // reset values and small typed constants
    localparam logic [GSPS_STAGES-1:0] GSPS_STAGE_RST = 8'h00;
    localparam logic [GSPS_PTR_W-1:0] GSPS_PTR_RST = 1'h0;
    localparam logic [GSPS_PTR_W-1:0] GSPS_PTR_ONE = 1'h1;
    localparam logic [GSPS_PTR_W-1:0] GSPS_PTR_LAST = 1'h1;
    localparam logic [GSPS_CNT_W-1:0] GSPS_CNT_RST = 2'h0;
    localparam logic [GSPS_CNT_W-1:0] GSPS_CNT_ONE = 2'h1;
    localparam logic [GSPS_CNT_W-1:0] GSPS_CNT_FULL = 2'h2;
    localparam logic GSPS_BIT_LOW = 1'h0;

    // =========================================================
    // pin group driven by the host
    typedef struct packed {
        logic shift_clk;
        logic ser_a;
        logic ser_b;
        logic async_zero_n;
    } gsps_pins_s;

    // =========================================================
    // the whole state of the shifter module
    typedef struct packed {
        logic [GSPS_STAGES-1:0] stage;
        logic shift_clk_prev;
        logic [GSPS_BUF_DEPTH-1:0][GSPS_STAGES-1:0] mem;
        logic [GSPS_PTR_W-1:0] wr_ptr;
        logic [GSPS_PTR_W-1:0] rd_ptr;
        logic [GSPS_CNT_W-1:0] count;
    } gsps_state_s;

endpackage

// [src/gsps_shifter.sv]
// Purpose: eight-stage serial-in parallel-out shifter with gated serial input
// Assumes: pins sampled on clk; shift_clk much slower than clk
// Notes: each shifted word is also offered on a two-entry stream buffer while it has room; a full buffer drops it
//
// Behaviour
// - eight stages in one chain, two serial inputs
// - serial bit is AND of both inputs
// - only a shift_clk rise or a low clear changes the stages
// - rise loads AND bit, moves others up
// - last stage value is dropped each rise
// - outputs shift exactly one position per rise while clear is high
// - low clear zeroes all stages, beats rise
// - no rise, clear high: stages hold
`timescale 1ns/1ps

module gsps_shifter
(
    input wire logic clk,
    input wire logic rst,
    input wire gsps_pkg::gsps_pins_s pins,
    output logic [gsps_pkg::GSPS_STAGES-1:0] stage_out,
    output logic snap_ready,
    output logic word_valid,
    input wire logic word_ready,
    output logic [gsps_pkg::GSPS_STAGES-1:0] word_data
);

    // =========================================================
    // state
    gsps_pkg::gsps_state_s st_r;
    gsps_pkg::gsps_state_s st_nxt;

    logic rise;
    logic fall;
    logic ser_bit;
    logic push;
    logic pop;

    // =========================================================
    // edge detect and gating; pins are already synchronous so no sync stage
    assign rise = pins.shift_clk & ~st_r.shift_clk_prev;
    assign fall = ~pins.shift_clk & st_r.shift_clk_prev;
    assign ser_bit = pins.ser_a & pins.ser_b;

    // buffer handshakes; a rise into a full buffer still shifts, word not kept
    assign pop = word_valid & word_ready;
    assign push = rise & pins.async_zero_n & snap_ready;

    // =========================================================
    // next state
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.shift_clk_prev = pins.shift_clk;
        if (!pins.async_zero_n)
        begin
            // clear wins over any edge seen in the same cycle
            st_nxt.stage = gsps_pkg::GSPS_STAGE_RST;
        end
        else if (rise)
        begin
            // top stage falls off the end, no carry out
            for (int i = gsps_pkg::GSPS_STAGES - 1; i > 0; i--)
            begin
                st_nxt.stage[i] = st_r.stage[i-1];
            end
            st_nxt.stage[0] = ser_bit;
        end
        // otherwise stages hold whatever the serial inputs do
        if (push)
        begin
            st_nxt.mem[st_r.wr_ptr] = st_nxt.stage;
            st_nxt.wr_ptr = (st_r.wr_ptr == gsps_pkg::GSPS_PTR_LAST)
                ? gsps_pkg::GSPS_PTR_RST : st_r.wr_ptr + gsps_pkg::GSPS_PTR_ONE;
        end
        if (pop)
        begin
            st_nxt.rd_ptr = (st_r.rd_ptr == gsps_pkg::GSPS_PTR_LAST)
                ? gsps_pkg::GSPS_PTR_RST : st_r.rd_ptr + gsps_pkg::GSPS_PTR_ONE;
        end
        if (push && !pop)
        begin
            st_nxt.count = st_r.count + gsps_pkg::GSPS_CNT_ONE;
        end
        else if (pop && !push)
        begin
            st_nxt.count = st_r.count - gsps_pkg::GSPS_CNT_ONE;
        end
    end

    // =========================================================
    // registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_r.stage <= gsps_pkg::GSPS_STAGE_RST;
            st_r.shift_clk_prev <= gsps_pkg::GSPS_BIT_LOW;
            st_r.mem <= '0;
            st_r.wr_ptr <= gsps_pkg::GSPS_PTR_RST;
            st_r.rd_ptr <= gsps_pkg::GSPS_PTR_RST;
            st_r.count <= gsps_pkg::GSPS_CNT_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // =========================================================
    // outputs: stages straight out, no latch or enable between
    assign stage_out = st_r.stage;
    assign snap_ready = (st_r.count != gsps_pkg::GSPS_CNT_FULL);
    assign word_valid = (st_r.count != gsps_pkg::GSPS_CNT_RST);
    assign word_data = st_r.mem[st_r.rd_ptr];

    // =========================================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_gate_and: assert property (
        rise && pins.async_zero_n |=> stage_out[0] == $past(pins.ser_a & pins.ser_b))
        else $error("first stage is not the AND of both serial inputs");

    chk_shift_one: assert property (
        rise && pins.async_zero_n |=> stage_out[7:1] == $past(stage_out[6:0]))
        else $error("stages did not move up one position");

    // rises are at least two cycles apart, so back-to-back rises never occur;
    // this follows a bit across two rises spaced six cycles, the host's pace
    chk_chain_walk: assert property (
        (rise && pins.async_zero_n) ##6 (rise && pins.async_zero_n)
        |=> stage_out[2] == $past(stage_out[0], 7))
        else $error("bit did not walk two stages in two edges");

    chk_top_drop: assert property (
        rise && pins.async_zero_n |=> stage_out[7] == $past(stage_out[6]))
        else $error("last stage did not take the seventh stage value");

    chk_hold_idle: assert property (
        pins.async_zero_n && !rise |=> $stable(stage_out))
        else $error("stages changed without a rising edge");

    chk_fall_ignored: assert property (
        fall && pins.async_zero_n |=> $stable(stage_out))
        else $error("falling edge changed the stages");

    chk_clear_zero: assert property (
        !pins.async_zero_n |=> stage_out == gsps_pkg::GSPS_STAGE_RST)
        else $error("clear did not zero every stage");

    chk_clear_hold: assert property (
        (!pins.async_zero_n && rise) ##1 pins.async_zero_n && !rise
        |=> stage_out == gsps_pkg::GSPS_STAGE_RST)
        else $error("edge during clear loaded data");

    // a shift can add at most the one new bit; the top bit leaves the chain
    chk_eight_deep: assert property (
        rise && pins.async_zero_n
        |=> $countones(stage_out) <= $countones($past(stage_out[6:0])) + 1)
        else $error("stage chain gained more than one bit");

    chk_word_stall: assert property (
        word_valid && !word_ready |=> word_valid && $stable(word_data))
        else $error("stalled word changed or vanished");

    chk_full_block: assert property (
        !snap_ready && !pop |=> word_valid && st_r.count == gsps_pkg::GSPS_CNT_FULL)
        else $error("full buffer lost an entry");

    // =========================================================
    // buffer checks; the stream side must never lose or invent a word

    // an accepted shift always leaves a word waiting
    chk_push_valid: assert property (
        push |=> word_valid)
        else $error("pushed word not offered");

    // into an empty buffer the offered word is the new stage value
    chk_push_data: assert property (
        push && !word_valid |=> word_data == stage_out)
        else $error("offered word differs from the stages");

    // a rise into a full buffer still shifts but keeps the buffer full
    chk_refuse_full: assert property (
        rise && pins.async_zero_n && !snap_ready && !pop |=> !snap_ready)
        else $error("full buffer changed on a refused word");

    // taking the only word empties the buffer
    chk_pop_empty: assert property (
        pop && !push && st_r.count == gsps_pkg::GSPS_CNT_ONE |=> !word_valid)
        else $error("buffer not empty after last pop");

    // clear only touches the stages; queued words are left alone
    chk_clear_keep: assert property (
        !pins.async_zero_n && !pop |=> $stable(word_valid))
        else $error("clear disturbed the word buffer");

    // a clear held low keeps every stage at zero
    chk_clear_stay: assert property (
        !pins.async_zero_n ##1 !pins.async_zero_n
        |-> stage_out == gsps_pkg::GSPS_STAGE_RST)
        else $error("stages left zero while clear held");

    // reset itself must empty the outputs, so this one is not disabled
    chk_reset_out: assert property (
        disable iff (1'b0)
        rst |=> stage_out == gsps_pkg::GSPS_STAGE_RST && !word_valid && snap_ready)
        else $error("reset did not empty the outputs");

    cov_shift_ones: cover property (
        rise && pins.async_zero_n && ser_bit ##1 stage_out[0]);
    cov_clear_edge: cover property (rise && !pins.async_zero_n);
    cov_buf_full: cover property (!snap_ready ##1 pop);
    cov_full_refuse: cover property (rise && pins.async_zero_n && !snap_ready);
    cov_drain: cover property (pop ##1 !word_valid);

endmodule

// [bench/gsps_host.sv]
// Purpose: host model that drives the shifter pins
// Assumes: pins change only at the falling clk edge
// Notes: serial data is inverted once its hold time is over
`timescale 1ns/1ps
module gsps_host
(
    input wire logic clk,
    output gsps_pkg::gsps_pins_s pins
);
    // ==========
    // pin idle levels
    initial pins = '{1'b0, 1'b0, 1'b0, 1'b1};
    // data is set a full cycle before the rise, so setup is met
    task automatic shift(input logic a, input logic b);
        @(negedge clk);
        pins.ser_a = a;
        pins.ser_b = b;
        @(negedge clk);
        pins.shift_clk = 1'b1;
        @(negedge clk);
        pins.ser_a = ~a;
        pins.ser_b = ~b;
        @(negedge clk);
        pins.shift_clk = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    // clear pulse, optionally with a rise in the same cycle
    task automatic zero(input logic rise);
        @(negedge clk);
        pins.async_zero_n = 1'b0;
        pins.shift_clk = rise;
        repeat (2) @(negedge clk);
        pins.async_zero_n = 1'b1;
        pins.shift_clk = 1'b0;
        repeat (2) @(negedge clk);
    endtask
endmodule

// [bench/testbench.sv]
// Purpose: self-checking bench of the gated serial shifter
// Assumes: host model drives pins, bench is the word sink
// Notes: expected stage value is rebuilt here on every shift
`timescale 1ns/1ps
module testbench;
    logic clk;
    logic rst;
    logic word_ready;
    gsps_pkg::gsps_pins_s pins;
    logic [7:0] stage_out;
    logic [7:0] word_data;
    logic snap_ready;
    logic word_valid;
    logic [7:0] exp;
    logic [7:0] w1;
    int error_cnt = 0;
    int tests_run = 0;
    gsps_host host (.clk(clk), .pins(pins));
    gsps_shifter dut (.clk(clk), .rst(rst), .pins(pins), .stage_out(stage_out),
        .snap_ready(snap_ready), .word_valid(word_valid), .word_ready(word_ready),
        .word_data(word_data));
    // ==========
    // clock, 40 ns period
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e)
        begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    // one shift, then the stage value against the model
    task automatic step(input logic a, input logic b);
        host.shift(a, b);
        exp = {exp[6:0], a & b};
        cmp("stage_out", exp, stage_out);
    endtask
    task automatic t_gate();
        for (int i = 0; i < 4; i++)
            step(i[1], i[0]);
    endtask
    // eight shifts push every older bit out of the chain
    task automatic t_walk();
        for (int i = 0; i < 8; i++)
            step(i[0], 1'b1);
        cmp("walk", 8'h55, stage_out);
    endtask
    task automatic t_clear();
        host.zero(1'b1);
        exp = 8'h00;
        cmp("cleared", exp, stage_out);
        step(1'b1, 1'b1);
    endtask
    // sink stalls: third word refused, first two kept in order
    task automatic t_buf();
        word_ready = 1'b0;
        step(1'b1, 1'b0);
        w1 = exp;
        step(1'b1, 1'b1);
        step(1'b1, 1'b1);
        cmp("snap_ready", 8'h00, {7'h00, snap_ready});
        cmp("word1", w1, word_data);
        @(negedge clk) word_ready = 1'b1;
        @(negedge clk) word_ready = 1'b0;
        cmp("word2", {w1[6:0], 1'b1}, word_data);
        @(negedge clk) word_ready = 1'b1;
        @(negedge clk);
        cmp("drained", 8'h00, {7'h00, word_valid});
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        rst = 1'b1;
        word_ready = 1'b1;
        exp = 8'h00;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        cmp("rst_stage", 8'h00, stage_out);
        cmp("rst_snap", 8'h01, {7'h00, snap_ready});
        t_gate();
        t_walk();
        t_clear();
        t_buf();
        tally_and_finish();
    end
    // watchdog, about eighteen times the expected run
    initial
    begin
        repeat (2000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end
endmodule
